// >>> design/capture_event_gen.sv
/*
 * edge detector and rising-edge prescaler that turns the capture input into capture pulses.
 * assumes the input is synchronous to mclk; one pulse at most per cycle.
 */
`timescale 1ns/1ps
`include "capture_regs.svh"

module capture_event_gen (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       enable,
    input  wire logic [3:0] mode,
    input  wire logic       sig_in,
    output logic            cap_pulse
);

    logic       prev_ff;
    logic [3:0] pre_ff;
    logic [3:0] nxt_pre;
    logic       rise;
    logic       fall;
    logic       pre_hit;
    logic [3:0] pre_last;

    // previous input level for edge detection
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= sig_in;
        end
    end

    assign rise = sig_in & ~prev_ff;
    assign fall = ~sig_in & prev_ff;

    assign pre_last = (mode == capture_pkg::MODE_RISE16) ? `PRE16_LAST : `PRE4_LAST;
    assign pre_hit  = rise && (pre_ff == pre_last);
    assign nxt_pre  = pre_hit ? 4'h0 : pre_ff + 4'h1;

    // prescaler restarts while disabled so a mode change starts a fresh count
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pre_ff <= 4'h0;
        end else if (!enable) begin
            pre_ff <= 4'h0;
        end else if (rise) begin
            pre_ff <= nxt_pre;
        end
    end

    always_comb begin
        cap_pulse = 1'b0;
        if (enable) begin
            case (mode)
                capture_pkg::MODE_EDGE:   cap_pulse = rise | fall;
                capture_pkg::MODE_RISE:   cap_pulse = rise;
                capture_pkg::MODE_FALL:   cap_pulse = fall;
                capture_pkg::MODE_BOTH:   cap_pulse = rise | fall;
                capture_pkg::MODE_RISE4:  cap_pulse = pre_hit;
                capture_pkg::MODE_RISE16: cap_pulse = pre_hit;
                default:                  cap_pulse = 1'b0;
            endcase
        end
    end

endmodule : capture_event_gen

// >>> design/capture_pkg.sv
/*
 * types shared by the input capture timer files.
 * assumes capture_regs.svh holds the numeric constants.
 */
package capture_pkg;

    // capture modes of the mode field
    typedef enum logic [3:0] {
        MODE_EDGE    = 4'b0000,
        MODE_RISE    = 4'b0001,
        MODE_FALL    = 4'b0010,
        MODE_BOTH    = 4'b0011,
        MODE_RISE4   = 4'b0100,
        MODE_RISE16  = 4'b0101
    } cap_mode_e;

    // synchronisation source codes
    typedef enum logic [4:0] {
        SYNC_OWN_TMR = 5'b00000,
        SYNC_OWN     = 5'b00001,
        SYNC_UNIT1   = 5'b00010,
        SYNC_UNIT7   = 5'b01000,
        SYNC_PAD0    = 5'b01001,
        SYNC_PAD2    = 5'b01011,
        SYNC_CELL1   = 5'b10000,
        SYNC_CELL4   = 5'b10011,
        SYNC_CMP1    = 5'b11000,
        SYNC_CMP3    = 5'b11010,
        SYNC_CONV    = 5'b11011,
        SYNC_CHARGE  = 5'b11100,
        SYNC_NONE    = 5'b11111
    } sync_src_e;

endpackage : capture_pkg

// >>> design/capture_regs.svh
/*
 * register offsets, field positions, reset values and codes of the input capture timer.
 * assumes it is included by bare name from the design files; definitions only.
 */
`ifndef CAPTURE_REGS_SVH
`define CAPTURE_REGS_SVH

// ***************************************************************
// register offsets
// ***************************************************************
`define OFS_CONTROL      8'h00
`define OFS_PERIOD       8'h04
`define OFS_COUNT_LO     8'h08
`define OFS_COUNT_HI     8'h0c
`define OFS_CAPTURE      8'h10
`define OFS_STATUS       8'h14
`define OFS_MASK         8'h18
`define OFS_FIFO_STAT    8'h1c

// ***************************************************************
// control fields
// ***************************************************************
`define CTL_MODE_LSB     0
`define CTL_MODE_MSB     3
`define CTL_CAPSEL_BIT   4
`define CTL_WIDE_BIT     5
`define CTL_TRIGSRC_BIT  6
`define CTL_ON_BIT       7
`define CTL_SYNC_LSB     8
`define CTL_SYNC_MSB     12
`define CTL_RESET        32'h0000_1f00
`define PERIOD_RESET     32'hffff_ffff

// ***************************************************************
// status bits, prescale and terminal values
// ***************************************************************
`define ST_CAPTURE_BIT   0
`define ST_OVERFLOW_BIT  1
`define ST_ROLL_BIT      2
`define ST_WIDTH         3
`define PRE4_LAST        4'h3
`define PRE16_LAST       4'hf
`define TERM16           32'h0000_ffff
`define TERM32           32'hffff_ffff
`define MASK16           32'h0000_ffff

`endif

// >>> design/input_capture_timer.sv
/*
 * input capture timer: control registers, dedicated up counter with selectable sync
 * source, capture fifo and a masked interrupt.
 * assumes a single mclk domain, synchronous inputs and a plain one-cycle register port.
 */
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "capture_regs.svh"

module input_capture_timer #(
    parameter int TIMER_W    = 32,
    parameter int FIFO_DEPTH = 4,
    parameter int PTR_W      = 2
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    input  wire logic        capture_pin,
    input  wire logic        internal_trigger,
    input  wire logic [6:0]  capture_unit_sync,
    input  wire logic [2:0]  external_interrupt_pad,
    input  wire logic [3:0]  logic_cell,
    input  wire logic [2:0]  comparator,
    input  wire logic        charge_time_unit,
    input  wire logic        converter_start,
    output logic             sync_out,
    output logic             irq
);

    // ***************************************************************
    // registers
    // ***************************************************************
    logic [31:0]             ctrl_ff;
    logic [31:0]             period_ff;
    logic [TIMER_W-1:0]      count_ff;
    logic [TIMER_W-1:0]      nxt_count;
    logic [TIMER_W-1:0]      shadow_ff;
    logic [31:0]             hi_latch_ff;
    logic [`ST_WIDTH-1:0]    status_ff;
    logic [`ST_WIDTH-1:0]    mask_ff;
    logic [31:0]             rdata_ff;
    logic                    irq_ff;
    logic                    sync_out_ff;
    logic                    tmr_sync_ff;
    logic                    sync_prev_ff;
    logic [31:0]             fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0]        wr_ptr_ff;
    logic [PTR_W-1:0]        rd_ptr_ff;
    logic [PTR_W:0]          level_ff;

    logic [3:0]  mode;
    logic        cap_sel;
    logic        wide;
    logic        unit_on;
    logic [4:0]  sync_sel;
    logic        cap_src;
    logic        cap_pulse;
    logic        sync_level;
    logic        sync_hit;
    logic        roll;
    logic [31:0] count_w;
    logic [31:0] term;
    logic [31:0] period_eff;
    logic        full;
    logic        empty;
    logic        push;
    logic        pop;
    logic        overflow;
    logic        wr_ctrl;
    logic        wr_status;
    logic [31:0] cap_word;
    logic [31:0] shadow_w;

    assign mode     = ctrl_ff[`CTL_MODE_MSB:`CTL_MODE_LSB];
    assign cap_sel  = ctrl_ff[`CTL_CAPSEL_BIT];
    assign wide     = ctrl_ff[`CTL_WIDE_BIT];
    assign unit_on  = ctrl_ff[`CTL_ON_BIT];
    assign sync_sel = ctrl_ff[`CTL_SYNC_MSB:`CTL_SYNC_LSB];
    assign wr_ctrl  = wr_stb && (addr == `OFS_CONTROL);
    assign wr_status = wr_stb && (addr == `OFS_STATUS);

    // ***************************************************************
    // control, period and mask registers
    // ***************************************************************
    // control register holds mode, capture select, width, source and sync code
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= `CTL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= {19'h0, wdata[`CTL_SYNC_MSB:0]};
        end
    end

    // period compare value
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            period_ff <= `PERIOD_RESET;
        end else if (wr_stb && (addr == `OFS_PERIOD)) begin
            period_ff <= wdata;
        end
    end

    // interrupt mask, same layout as status
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= '0;
        end else if (wr_stb && (addr == `OFS_MASK)) begin
            mask_ff <= wdata[`ST_WIDTH-1:0];
        end
    end

    // ***************************************************************
    // sync source selection
    // ***************************************************************
    // sync code decode
    always_comb begin
        sync_level = 1'b0;
        if (sync_sel >= capture_pkg::SYNC_UNIT1 && sync_sel <= capture_pkg::SYNC_UNIT7) begin
            sync_level = capture_unit_sync[3'(sync_sel - capture_pkg::SYNC_UNIT1)];
        end else if (sync_sel >= capture_pkg::SYNC_PAD0 &&
                     sync_sel <= capture_pkg::SYNC_PAD2) begin
            sync_level = external_interrupt_pad[2'(sync_sel - capture_pkg::SYNC_PAD0)];
        end else if (sync_sel >= capture_pkg::SYNC_CELL1 &&
                     sync_sel <= capture_pkg::SYNC_CELL4) begin
            sync_level = logic_cell[2'(sync_sel - capture_pkg::SYNC_CELL1)];
        end else if (sync_sel >= capture_pkg::SYNC_CMP1 &&
                     sync_sel <= capture_pkg::SYNC_CMP3) begin
            sync_level = comparator[2'(sync_sel - capture_pkg::SYNC_CMP1)];
        end else begin
            case (sync_sel)
                capture_pkg::SYNC_OWN_TMR: sync_level = tmr_sync_ff;
                capture_pkg::SYNC_OWN:     sync_level = sync_out_ff;
                capture_pkg::SYNC_CONV:    sync_level = converter_start;
                capture_pkg::SYNC_CHARGE:  sync_level = charge_time_unit;
                default:                   sync_level = 1'b0; // reserved and none
            endcase
        end
    end

    // only the rising edge resets the timer, so a long trigger level holds no reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sync_prev_ff <= 1'b0;
        end else begin
            sync_prev_ff <= sync_level;
        end
    end

    assign sync_hit = sync_level & ~sync_prev_ff;

    // ***************************************************************
    // dedicated capture timer
    // ***************************************************************
    assign count_w    = 32'(count_ff);
    assign term       = wide ? `TERM32 : `TERM16;
    assign period_eff = wide ? period_ff : (period_ff & `MASK16);
    // rollover on period match or terminal value
    assign roll       = (count_w == period_eff) || (count_w == term);

    // synchronous up count, 16 or 32 bits
    always_comb begin
        if (!unit_on) begin
            nxt_count = '0;
        end else if (sync_hit || roll) begin
            nxt_count = '0;
        end else begin
            nxt_count = count_ff + TIMER_W'(1);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // own sync outputs pulse on rollover; sync_out also pulses on a sync hit
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tmr_sync_ff <= 1'b0;
            sync_out_ff <= 1'b0;
        end else begin
            tmr_sync_ff <= unit_on && roll;
            sync_out_ff <= unit_on && (roll || sync_hit);
        end
    end

    // sync stage delays the readable count by one cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shadow_ff <= '0;
        end else begin
            shadow_ff <= count_ff;
        end
    end

    assign shadow_w = 32'(shadow_ff);

    // ***************************************************************
    // capture event and fifo
    // ***************************************************************
    // pin or internal trigger
    assign cap_src = ctrl_ff[`CTL_TRIGSRC_BIT] ? internal_trigger : capture_pin;

    // capture select gates the capture path
    capture_event_gen u_event (
        .mclk      (mclk),
        .resetn    (resetn),
        .enable    (unit_on && cap_sel),
        .mode      (mode),
        .sig_in    (cap_src),
        .cap_pulse (cap_pulse)
    );

    assign full     = (level_ff == (PTR_W+1)'(FIFO_DEPTH));
    assign empty    = (level_ff == '0);
    assign pop      = rd_stb && (addr == `OFS_CAPTURE) && !empty;
    // a pop in the same cycle frees the slot for the new capture
    assign push     = cap_pulse && (!full || pop);
    assign overflow = cap_pulse && full && !pop;
    // 16-bit captures store the low half only
    assign cap_word = wide ? count_w : (count_w & `MASK16);

    always_ff @(posedge mclk) begin
        if (push) begin
            fifo_mem[wr_ptr_ff] <= cap_word;
        end
    end

    // pointers and level; a full fifo drops the newest capture
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            level_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == PTR_W'(FIFO_DEPTH-1)) ? '0 : wr_ptr_ff + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == PTR_W'(FIFO_DEPTH-1)) ? '0 : rd_ptr_ff + PTR_W'(1);
            end
            level_ff <= level_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // ***************************************************************
    // status and interrupt
    // ***************************************************************
    // sticky events; a new event wins over a same-cycle write-one clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_ff <= '0;
        end else begin
            status_ff <= (status_ff & ~(wr_status ? wdata[`ST_WIDTH-1:0] : '0))
                       | {unit_on && roll, overflow, push};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // ***************************************************************
    // read port
    // ***************************************************************
    // low count read latches the high half so a 32-bit pair reads coherently
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            hi_latch_ff <= '0;
        end else if (rd_stb && (addr == `OFS_COUNT_LO)) begin
            hi_latch_ff <= {16'h0, shadow_w[31:16]};
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= '0;
        end else if (rd_stb) begin
            case (addr)
                `OFS_CONTROL:   rdata_ff <= ctrl_ff;
                `OFS_PERIOD:    rdata_ff <= period_ff;
                `OFS_COUNT_LO:  rdata_ff <= {16'h0, shadow_w[15:0]};
                `OFS_COUNT_HI:  rdata_ff <= hi_latch_ff;
                `OFS_CAPTURE:   rdata_ff <= empty ? 32'h0 : fifo_mem[rd_ptr_ff];
                `OFS_STATUS:    rdata_ff <= 32'(status_ff);
                `OFS_MASK:      rdata_ff <= 32'(mask_ff);
                `OFS_FIFO_STAT: rdata_ff <= {full, 28'h0, level_ff};
                default:        rdata_ff <= 32'h0;
            endcase
        end else begin
            rdata_ff <= 32'h0;
        end
    end

    assign rdata    = rdata_ff;
    assign irq      = irq_ff;
    assign sync_out = sync_out_ff;

endmodule : input_capture_timer

// >>> verif/capture_source.sv
/*
 * model of the capture pin, trigger and sync lines.
 * assumes lines change only after rising mclk edges.
 */
`timescale 1ns/1ps

module capture_source (
    input  wire logic mclk,
    output logic      capture_pin,
    output logic      internal_trigger,
    output logic [6:0] capture_unit_sync,
    output logic [2:0] external_interrupt_pad,
    output logic [3:0] logic_cell,
    output logic [2:0] comparator,
    output logic      charge_time_unit,
    output logic      converter_start
);
    logic [20:0] lines = 21'h0;

    // one vector for all lines, pin at 19 and trigger at 20
    assign {internal_trigger, capture_pin, converter_start, charge_time_unit, comparator,
            logic_cell, external_interrupt_pad, capture_unit_sync} = lines;

    task automatic edges(input int n, input int gap, input logic trig);
        for (int i = 0; i < n; i++) begin
            repeat (gap) @(posedge mclk);
            lines[trig ? 20 : 19] <= 1'b1;
            repeat (gap) @(posedge mclk);
            lines[trig ? 20 : 19] <= 1'b0;
        end
    endtask : edges

    // two-cycle pulse on one sync line
    task automatic sync_pulse(input int sel);
        @(posedge mclk);
        lines[sel] <= 1'b1;
        repeat (2) @(posedge mclk);
        lines[sel] <= 1'b0;
    endtask : sync_pulse
endmodule : capture_source

// >>> verif/capture_timer_sva.sv
/*
 * port-level checker of the input capture timer.
 * assumes one mclk domain, resetn async low.
 */
`timescale 1ns/1ps

module capture_timer_sva (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata,
    input wire logic        capture_pin,
    input wire logic        internal_trigger,
    input wire logic [2:0]  external_interrupt_pad,
    input wire logic        charge_time_unit,
    input wire logic        sync_out,
    input wire logic        irq
);
    logic [31:0] ctl_ff;
    logic [1:0]  mask_ff;
    logic        armed;

    // control shadow: the checker sees only ports
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ctl_ff <= 32'h0000_1f00;
        end else if (wr_stb && addr == 8'h00) begin
            ctl_ff <= wdata;
        end
    end

    // shadow of the low mask bits
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mask_ff <= 2'h0;
        end else if (wr_stb && addr == 8'h18) begin
            mask_ff <= wdata[1:0];
        end
    end

    // overflow unmasked too, so a full fifo still raises irq
    assign armed = ctl_ff[7] && ctl_ff[4] && mask_ff == 2'h3;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_rd(a);
        rd_stb && addr == a;
    endsequence
    sequence s_irq_later;
        ##2 irq;
    endsequence

    property p_rdata_idle;
        !rd_stb |=> rdata == 32'h0;
    endproperty
    property p_rise;
        armed && !ctl_ff[6] && ctl_ff[3:0] == 4'h1 && $rose(capture_pin) |-> s_irq_later;
    endproperty
    property p_fall;
        armed && !ctl_ff[6] && ctl_ff[3:0] == 4'h2 && $fell(capture_pin) |-> s_irq_later;
    endproperty
    property p_both;
        armed && !ctl_ff[6] && ctl_ff[3:0] inside {4'h0, 4'h3}
            && $changed(capture_pin) |-> s_irq_later;
    endproperty
    property p_trig;
        armed && ctl_ff[6] && ctl_ff[3:0] == 4'h1 && $rose(internal_trigger) |-> s_irq_later;
    endproperty
    property p_count_up;
        (ctl_ff[7] && ctl_ff[12:8] == 5'h1f) ##0 s_rd(8'h08) ##1 s_rd(8'h08)
            |=> rdata == $past(rdata) + 32'h1;
    endproperty
    property p_wide16;
        s_rd(8'h10) and !ctl_ff[5] |=> rdata[31:16] == 16'h0;
    endproperty
    property p_sync_pad;
        ctl_ff[7] && ctl_ff[12:8] == 5'h09 && $rose(external_interrupt_pad[0])
            |-> ##[1:3] sync_out;
    endproperty
    property p_sync_charge;
        ctl_ff[7] && ctl_ff[12:8] == 5'h1c && $rose(charge_time_unit) |-> ##[1:3] sync_out;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero when idle");
    a_rise: assert property (p_rise)
        else $error("no irq after rise");
    a_fall: assert property (p_fall)
        else $error("no irq after fall");
    a_both: assert property (p_both)
        else $error("no irq after edge");
    a_trig: assert property (p_trig)
        else $error("no irq after trigger");
    a_count_up: assert property (p_count_up)
        else $error("count step not one");
    a_wide16: assert property (p_wide16)
        else $error("narrow capture upper bits set");
    a_sync_pad: assert property (p_sync_pad)
        else $error("no sync after pad");
    a_sync_charge: assert property (p_sync_charge)
        else $error("no sync after charge unit");
endmodule : capture_timer_sva

bind input_capture_timer capture_timer_sva i_capture_timer_sva (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .capture_pin(capture_pin),
    .internal_trigger(internal_trigger), .external_interrupt_pad(external_interrupt_pad),
    .charge_time_unit(charge_time_unit), .sync_out(sync_out), .irq(irq)
);

// >>> verif/input_capture_timer_bench.sv
/*
 * self-checking bench of the input capture timer.
 * assumes mclk at 50 MHz.
 */
`timescale 1ns/1ps

module input_capture_timer_bench;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [31:0] rdata;
    logic        capture_pin, internal_trigger, charge_time_unit, converter_start;
    logic [6:0]  capture_unit_sync;
    logic [2:0]  external_interrupt_pad, comparator;
    logic [3:0]  logic_cell;
    logic        sync_out, irq;
    logic [31:0] got, v0;
    int          n_fail = 0, n_compared = 0, n_sync = 0;

    input_capture_timer i_input_capture_timer (
        .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .capture_pin(capture_pin),
        .internal_trigger(internal_trigger), .capture_unit_sync(capture_unit_sync),
        .external_interrupt_pad(external_interrupt_pad), .logic_cell(logic_cell),
        .comparator(comparator), .charge_time_unit(charge_time_unit),
        .converter_start(converter_start), .sync_out(sync_out), .irq(irq)
    );
    capture_source i_capture_source (
        .mclk(mclk), .capture_pin(capture_pin), .internal_trigger(internal_trigger),
        .capture_unit_sync(capture_unit_sync), .external_interrupt_pad(external_interrupt_pad),
        .logic_cell(logic_cell), .comparator(comparator), .charge_time_unit(charge_time_unit),
        .converter_start(converter_start)
    );

    always #10 mclk = ~mclk;

    // sync pulses seen before each edge
    always @(posedge mclk) if (sync_out === 1'b1) n_sync <= n_sync + 1;

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk32

    task automatic chk1(input string what, input logic exp, input logic seen);
        chk32(what, 32'(exp), 32'(seen));
    endtask : chk1

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 got = rdata;
    endtask : rd

    function automatic logic [31:0] ctl(logic [3:0] m, logic w, logic t, logic [4:0] s);
        return {19'h0, s, 1'b1, t, w, 1'b1, m};
    endfunction : ctl

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic wait_irq(input logic lvl);
        int k = 0;
        while (irq !== lvl && k < 10) begin
            @(posedge mclk);
            #1 k++;
        end
        chk1("irq", lvl, irq);
        if (k == 10) stop_test();
    endtask : wait_irq

    // unit off keeps the fifo: pop four, clear status
    task automatic flush;
        wr(8'h00, 32'h0000_1f00);
        repeat (4) rd(8'h10);
        wr(8'h14, 32'h7);
        wait_irq(1'b0);
    endtask : flush

    task automatic t_reset;
        rd(8'h00);
        chk32("control", 32'h0000_1f00, got);
        rd(8'h04);
        chk32("period", 32'hffff_ffff, got);
        wr(8'h20, 32'hff);
        rd(8'h20);
        chk32("unmapped", 32'h0, got);
        $display("done reset");
    endtask : t_reset

    task automatic t_irq;
        wr(8'h18, 32'h0);
        wr(8'h00, ctl(4'h1, 1'b1, 1'b0, 5'h1f));
        i_capture_source.edges(1, 2, 1'b0);
        rd(8'h14);
        chk32("status", 32'h1, got);
        chk1("masked irq", 1'b0, irq);
        wr(8'h18, 32'h3);
        wait_irq(1'b1);
        wr(8'h14, 32'h1);
        wait_irq(1'b0);
        flush();
        $display("done irq");
    endtask : t_irq

    task automatic t_modes;
        for (int m = 0; m < 6; m++) begin
            wr(8'h00, ctl(m[3:0], 1'b1, 1'b0, 5'h1f));
            i_capture_source.edges((m < 4) ? 2 : ((m == 4) ? 7 : 31), (m < 4) ? 3 : 1, 1'b0);
            repeat (3) @(posedge mclk);
            rd(8'h1c);
            v0 = (m == 0 || m == 3) ? 32'h8000_0004 : ((m > 3) ? 32'h1 : 32'h2);
            chk32("fifo level", v0, got);
            wait_irq(1'b1);
            flush();
        end
        $display("done modes");
    endtask : t_modes

    task automatic t_value;
        wr(8'h00, ctl(4'h1, 1'b0, 1'b0, 5'h1f));
        i_capture_source.edges(2, 5, 1'b0);
        rd(8'h10);
        v0 = got;
        rd(8'h10);
        chk32("capture spacing", 32'd10, got - v0);
        chk32("upper half", 32'h0, got & 32'hffff_0000);
        flush();
        wr(8'h00, ctl(4'h1, 1'b1, 1'b1, 5'h1f));
        i_capture_source.edges(1, 2, 1'b0);
        i_capture_source.edges(1, 2, 1'b1);
        repeat (3) @(posedge mclk);
        rd(8'h1c);
        chk32("trigger only", 32'h1, got);
        flush();
        $display("done value");
    endtask : t_value

    task automatic t_count;
        wr(8'h00, ctl(4'h1, 1'b1, 1'b0, 5'h1f));
        repeat (4) @(posedge mclk);
        addr <= 8'h08;
        rd_stb <= 1'b1;
        @(posedge mclk);
        #1 v0 = rdata;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 got = rdata;
        chk32("count step", 32'h1, got - v0);
        rd(8'h0c);
        chk32("count high", 32'h0, got);
        $display("done count");
    endtask : t_count

    task automatic t_sync;
        logic [4:0] code [10] = '{5'h02, 5'h08, 5'h09, 5'h0b, 5'h10,
                                  5'h13, 5'h18, 5'h1a, 5'h1b, 5'h1c};
        int         sel [10] = '{0, 6, 7, 9, 10, 13, 14, 16, 18, 17};
        int         s0;
        for (int i = 0; i < 10; i++) begin
            wr(8'h00, ctl(4'h1, 1'b1, 1'b0, code[i]));
            repeat (20) @(posedge mclk);
            s0 = n_sync;
            i_capture_source.sync_pulse(sel[i]);
            rd(8'h08);
            chk1("count restarted", 1'b1, got <= 32'd6);
            repeat (2) @(posedge mclk);
            chk1("sync pulse", 1'b1, n_sync > s0);
        end
        $display("done sync");
    endtask : t_sync

    // off first: a period below the running count would never match
    task automatic t_period;
        logic [4:0] code [3] = '{5'h1f, 5'h00, 5'h01};
        int         s0;
        flush();
        wr(8'h04, 32'h5);
        for (int i = 0; i < 3; i++) begin
            wr(8'h00, ctl(4'h1, 1'b1, 1'b0, code[i]));
            s0 = n_sync;
            repeat (8) begin
                rd(8'h08);
                chk1("within period", 1'b1, got <= 32'd5);
            end
            chk1("rollover pulse", 1'b1, n_sync > s0);
        end
        $display("done period");
    endtask : t_period

    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_irq();
        t_modes();
        t_value();
        t_count();
        t_sync();
        t_period();
        stop_test();
    end
endmodule : input_capture_timer_bench
